/* File: logic/pors_sequencer.sv */
// power-on reset sequencer with ahb-lite register slave
// Operation
// - power-on, brown-out, watchdog and pin reset all reset the core to program top
// - every reset loads the program counter with 07FF
// - power-up sets the reset latch, holding the core in reset
// - internal reset is the reset latch ORed with brown-out and watchdog, registered
// - delay counter starts only once master clear reads high
// - delay counter terminal count clears the latch, ending reset
// - the 10-bit delay counter serves the power-on sequence only
// - brown-out indication holds internal reset for its whole duration
// - brown-out reset releases once the supply indication recovers
// - two-bit brown-out config field can disable the brown-out reset
// - watchdog reset sets flags 00 in power-down, 01 when active
// - pin reset in power-down sets flags 10; active leaves them
`timescale 1ns/10ps
`default_nettype none

module pors_sequencer #(
    parameter int unsigned TICK_CYCLES = pors_pkg::DELAY_TICK_CYCLES,
    parameter int unsigned DELAY_BITS = pors_pkg::DELAY_BITS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic masterClearInput,
    input wire logic brownoutDetect,
    input wire logic watchdogTimeout,
    input wire logic powerDownMode,
    output logic coreReset,
    output logic [10:0] resetVector,
    output logic timeoutFlag,
    output logic powerdownFlag
);

    localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [DELAY_BITS-1:0] DELAY_LAST = {DELAY_BITS{1'b1}};

    // pin synchronisers
    logic mclrMeta;
    logic mclrSync;
    logic mclrPrev;
    logic borMeta;
    logic borSync;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mclrMeta <= 1'b0;
            mclrSync <= 1'b0;
            mclrPrev <= 1'b0;
            borMeta <= 1'b0;
            borSync <= 1'b0;
        end
        else
        begin
            mclrMeta <= masterClearInput;
            mclrSync <= mclrMeta;
            mclrPrev <= mclrSync;
            borMeta <= brownoutDetect;
            borSync <= borMeta;
        end
    end

    // configuration and derived conditions
    logic [1:0] borCfg;
    logic [1:0] next_borCfg;
    logic borActive;
    logic mclrFall;

    assign borActive = borSync && (borCfg != pors_pkg::BOR_CFG_OFF);
    assign mclrFall = mclrPrev && !mclrSync;

    // sequencer: latch, delay counter and its tick prescaler
    pors_pkg::pors_state_e state;
    pors_pkg::pors_state_e next_state;
    logic [DELAY_BITS-1:0] delayCount;
    logic [DELAY_BITS-1:0] next_delayCount;
    logic [TW-1:0] tickCount;
    logic [TW-1:0] next_tickCount;

    always_comb
    begin
        next_state = state;
        next_delayCount = delayCount;
        next_tickCount = tickCount;
        case (state)
            pors_pkg::SEQ_HOLD:
            begin
                next_delayCount = '0;
                next_tickCount = '0;
                if (mclrSync)
                    next_state = pors_pkg::SEQ_DELAY;
            end
            pors_pkg::SEQ_DELAY:
            begin
                if (!mclrSync)
                begin
                    next_state = pors_pkg::SEQ_HOLD;
                    next_delayCount = '0;
                    next_tickCount = '0;
                end
                else if (tickCount == TICK_LAST)
                begin
                    next_tickCount = '0;
                    next_delayCount = delayCount + 1'b1;
                    if (delayCount == DELAY_LAST)
                        next_state = pors_pkg::SEQ_RUN;
                end
                else
                    next_tickCount = tickCount + 1'b1;
            end
            pors_pkg::SEQ_RUN:
            begin
                if (!mclrSync)
                    next_state = pors_pkg::SEQ_EXT;
            end
            pors_pkg::SEQ_EXT:
            begin
                // pin reset after power-up skips the delay counter
                next_delayCount = '0;
                next_tickCount = '0;
                if (mclrSync)
                    next_state = pors_pkg::SEQ_RUN;
            end
            default:
                next_state = pors_pkg::SEQ_HOLD;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= pors_pkg::SEQ_HOLD;
            delayCount <= '0;
            tickCount <= '0;
        end
        else
        begin
            state <= next_state;
            delayCount <= next_delayCount;
            tickCount <= next_tickCount;
        end
    end

    // internal reset and reset vector
    logic next_coreReset;

    always_comb
    begin
        next_coreReset = (next_state != pors_pkg::SEQ_RUN)
            || borActive
            || watchdogTimeout;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            coreReset <= 1'b1;
            resetVector <= pors_pkg::PC_TOP;
        end
        else
        begin
            coreReset <= next_coreReset;
            resetVector <= pors_pkg::PC_TOP;
        end
    end

    // ahb-lite address phase capture
    logic addrValid;
    logic dpWrite;
    logic next_dpWrite;
    logic [7:0] dpAddr;
    logic [7:0] next_dpAddr;
    logic [31:0] next_hrdata;
    logic [31:0] readWord;
    logic statusWrite;
    logic configWrite;
    pors_pkg::pors_cause_e cause;
    pors_pkg::pors_cause_e next_cause;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrValid = hsel && hready && htrans[1];
    assign statusWrite = dpWrite && (dpAddr == pors_pkg::ADDR_STATUS);
    assign configWrite = dpWrite && (dpAddr == pors_pkg::ADDR_CONFIG);

    always_comb
    begin
        readWord = 32'h0000_0000;
        case (haddr[7:0])
            pors_pkg::ADDR_CONFIG:
                readWord[pors_pkg::CFG_BOR_LSB +: 2] = borCfg;
            pors_pkg::ADDR_STATUS:
            begin
                readWord[pors_pkg::ST_RESET_BIT] = coreReset;
                readWord[pors_pkg::ST_TIMEOUT_BIT] = timeoutFlag;
                readWord[pors_pkg::ST_PDOWN_BIT] = powerdownFlag;
                readWord[pors_pkg::ST_BROWNOUT_BIT] = borActive;
                readWord[pors_pkg::ST_MASTER_CLEAR_INPUT_BIT] = mclrSync;
                readWord[pors_pkg::ST_STATE_LSB +: 2] = state;
                readWord[pors_pkg::ST_CAUSE_LSB +: 2] = cause;
            end
            pors_pkg::ADDR_COUNT:
                readWord[DELAY_BITS-1:0] = delayCount;
            default:
                readWord = 32'h0000_0000;
        endcase
    end

    always_comb
    begin
        next_dpWrite = 1'b0;
        next_dpAddr = dpAddr;
        next_hrdata = hrdata;
        if (addrValid)
        begin
            next_dpWrite = hwrite && (hsize == pors_pkg::HSIZE_WORD) && (haddr[31:8] == 24'h00_0000);
            next_dpAddr = haddr[7:0];
            if (!hwrite)
            begin
                next_hrdata = (haddr[31:8] == 24'h00_0000) ? readWord : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dpWrite <= 1'b0;
            dpAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            dpWrite <= next_dpWrite;
            dpAddr <= next_dpAddr;
            hrdata <= next_hrdata;
        end
    end

    // config register
    always_comb
    begin
        next_borCfg = borCfg;
        if (configWrite)
        begin
            next_borCfg = hwdata[pors_pkg::CFG_BOR_LSB +: 2];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            borCfg <= pors_pkg::BOR_CFG_RESET;
        end
        else
        begin
            borCfg <= next_borCfg;
        end
    end

    // timeout and power-down flags, reset cause
    logic [1:0] next_flags;
    logic borPrev;
    logic extReset;

    assign extReset = mclrFall && (state == pors_pkg::SEQ_RUN);

    always_comb
    begin
        next_flags = {timeoutFlag, powerdownFlag};
        next_cause = cause;
        if (statusWrite)
        begin
            next_flags = {hwdata[pors_pkg::ST_TIMEOUT_BIT], hwdata[pors_pkg::ST_PDOWN_BIT]};
        end
        // hardware events win over a software write in the same cycle
        if (borActive && !borPrev)
        begin
            next_cause = pors_pkg::CAUSE_BOR;
        end
        if (extReset)
        begin
            next_cause = pors_pkg::CAUSE_EXT;
            if (powerDownMode)
            begin
                next_flags = pors_pkg::FLAGS_EXT_SLEEP;
            end
        end
        if (watchdogTimeout)
        begin
            next_cause = pors_pkg::CAUSE_WDT;
            next_flags = powerDownMode ? pors_pkg::FLAGS_WDT_SLEEP
                : pors_pkg::FLAGS_WDT_ACTIVE;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            timeoutFlag <= pors_pkg::FLAGS_POR[1];
            powerdownFlag <= pors_pkg::FLAGS_POR[0];
            cause <= pors_pkg::CAUSE_POR;
            borPrev <= 1'b0;
        end
        else
        begin
            timeoutFlag <= next_flags[1];
            powerdownFlag <= next_flags[0];
            cause <= next_cause;
            borPrev <= borActive;
        end
    end

endmodule // pors_sequencer

`default_nettype wire

/* File: pkg/pors_pkg.sv */
// constants and types for the power-on reset sequencer
`default_nettype none

package pors_pkg;

    // clock and release delay timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned RELEASE_DELAY_US = 72000;
    localparam int unsigned RELEASE_DELAY_CYCLES = RELEASE_DELAY_US * CLK_MHZ;
    localparam int unsigned DELAY_BITS = 10;
    // one delay-counter step, rounded down so the whole delay never overruns
    localparam int unsigned DELAY_TICK_CYCLES = RELEASE_DELAY_CYCLES / (1 << DELAY_BITS);

    // program counter value loaded by every reset
    localparam logic [10:0] PC_TOP = 11'h7FF;

    // register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;

    // config register fields
    localparam int unsigned CFG_BOR_LSB = 0;
    localparam logic [1:0] BOR_CFG_RESET = 2'h0;
    localparam logic [1:0] BOR_CFG_OFF = 2'h3;

    // status register fields
    localparam int unsigned ST_RESET_BIT = 0;
    localparam int unsigned ST_TIMEOUT_BIT = 1;
    localparam int unsigned ST_PDOWN_BIT = 2;
    localparam int unsigned ST_BROWNOUT_BIT = 3;
    localparam int unsigned ST_MASTER_CLEAR_INPUT_BIT = 4;
    localparam int unsigned ST_STATE_LSB = 8;
    localparam int unsigned ST_CAUSE_LSB = 12;

    // timeout and power-down flags after power-on, watchdog reset and pin reset
    localparam logic [1:0] FLAGS_POR = 2'h3;
    localparam logic [1:0] FLAGS_WDT_SLEEP = 2'h0;
    localparam logic [1:0] FLAGS_WDT_ACTIVE = 2'h1;
    localparam logic [1:0] FLAGS_EXT_SLEEP = 2'h2;

    // ahb encodings
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [1:0] {
        SEQ_HOLD = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_RUN = 2'b10,
        SEQ_EXT = 2'b11
    } pors_state_e;

    typedef enum logic [1:0] {
        CAUSE_POR = 2'b00,
        CAUSE_BOR = 2'b01,
        CAUSE_WDT = 2'b10,
        CAUSE_EXT = 2'b11
    } pors_cause_e;

endpackage

`default_nettype wire

/* File: sim/pors_sequencer_properties.sv */
// assertion checker for the reset sequencer ports
`timescale 1ns/10ps
`default_nettype none

module pors_seq_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic masterClearInput,
    input wire logic watchdogTimeout,
    input wire logic powerDownMode,
    input wire logic coreReset,
    input wire logic [10:0] resetVector,
    input wire logic timeoutFlag,
    input wire logic powerdownFlag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    vector_top_a: assert property (resetVector == 11'h7FF)
        else $error("vector not at top");
    por_flags_a: assert property ($rose(arst_n) |-> coreReset && timeoutFlag && powerdownFlag)
        else $error("power-on state wrong");
    por_hold_a: assert property ($rose(arst_n) |-> coreReset [*8])
        else $error("power-on hold too short");
    wdt_reset_a: assert property (watchdogTimeout |=> coreReset)
        else $error("watchdog gave no reset");
    wdt_active_a: assert property (watchdogTimeout && !powerDownMode |=> {timeoutFlag, powerdownFlag} == 2'h1)
        else $error("watchdog active flags");
    wdt_sleep_a: assert property (watchdogTimeout && powerDownMode |=> {timeoutFlag, powerdownFlag} == 2'h0)
        else $error("watchdog sleep flags");
    master_clear_input_hold_a: assert property (!masterClearInput [*6] |-> coreReset)
        else $error("reset dropped with pin low");
    release_master_clear_input_a: assert property ($fell(coreReset) |-> $past(masterClearInput, 2))
        else $error("release without pin high");

    cover property ($fell(coreReset));
    cover property (watchdogTimeout && powerDownMode);
    cover property ($fell(masterClearInput) && powerDownMode);
endmodule // pors_seq_checker

bind pors_sequencer pors_seq_checker u_chk (
    .clk(clk),
    .arst_n(arst_n),
    .masterClearInput(masterClearInput),
    .watchdogTimeout(watchdogTimeout),
    .powerDownMode(powerDownMode),
    .coreReset(coreReset),
    .resetVector(resetVector),
    .timeoutFlag(timeoutFlag),
    .powerdownFlag(powerdownFlag)
);

`default_nettype wire

/* File: sim/pors_board_model.sv */
// board model: master clear rc rise and supply sag detector
`timescale 1ns/10ps
`default_nettype none

module pors_board_model #(
    parameter int RC_CYCLES = 4
) (
    input wire logic clk,
    input wire logic pinHold,
    input wire logic sag,
    output logic masterClearInput,
    output logic brownoutDetect
);
    int rcCount = 0;

    // pin low discharges at once, rises after the rc delay
    always @(posedge clk)
        rcCount <= pinHold ? 0 : (rcCount < RC_CYCLES ? rcCount + 1 : rcCount);
    assign masterClearInput = (rcCount == RC_CYCLES);
    assign brownoutDetect = sag;
endmodule // pors_board_model

`default_nettype wire

/* File: sim/test_power_on_reset_sequencer.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
`default_nettype none

module test_power_on_reset_sequencer;
    localparam int TICK = 2;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic watchdogTimeout = 1'b0;
    logic powerDownMode = 1'b0;
    logic pinHold = 1'b1;
    logic sag = 1'b0;
    logic hreadyout, hresp, masterClearInput, brownoutDetect;
    logic coreReset, timeoutFlag, powerdownFlag;
    logic [10:0] resetVector;
    logic [31:0] hrdata, q;
    int error_cnt = 0;
    int checks_done = 0;

    always #2 clk = ~clk;

    pors_sequencer #(.TICK_CYCLES(TICK), .DELAY_BITS(10)) u_dut (
        .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .masterClearInput(masterClearInput), .brownoutDetect(brownoutDetect),
        .watchdogTimeout(watchdogTimeout), .powerDownMode(powerDownMode),
        .coreReset(coreReset), .resetVector(resetVector),
        .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag)
    );

    pors_board_model #(.RC_CYCLES(4)) u_board (
        .clk(clk), .pinHold(pinHold), .sag(sag),
        .masterClearInput(masterClearInput), .brownoutDetect(brownoutDetect)
    );

    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic drive_pin(input logic hold, input int n);
        @(posedge clk);
        pinHold <= hold;
        tick(n);
    endtask

    task automatic t_power_on();
        tick(1);
        chk("core reset", coreReset, 1);
        chk("flags", {timeoutFlag, powerdownFlag}, pors_pkg::FLAGS_POR);
        chk("vector", resetVector, pors_pkg::PC_TOP);
        bus(0, pors_pkg::ADDR_CONFIG, 0);
        chk("config", q, 0);
        drive_pin(0, 20);
        bus(0, pors_pkg::ADDR_COUNT, 0);
        chk("count runs", q[9:0] != 0, 1);
        drive_pin(1, 8);
        bus(0, pors_pkg::ADDR_COUNT, 0);
        chk("count held", q, 0);
        chk("core reset", coreReset, 1);
        drive_pin(0, 4 + 1024 * TICK - 8);
        chk("delay hold", coreReset, 1);
        repeat (40)
        begin
            if (coreReset === 1'b0)
                break;
            tick(1);
        end
        chk("released", coreReset, 0);
        bus(0, pors_pkg::ADDR_STATUS, 0);
        chk("state", q[9:8], 2);
    endtask

    task automatic t_watchdog();
        for (int pd = 0; pd < 2; pd++)
        begin
            @(posedge clk);
            powerDownMode <= pd[0];
            watchdogTimeout <= 1'b1;
            @(posedge clk);
            watchdogTimeout <= 1'b0;
            #1;
            chk("wdt reset", coreReset, 1);
            chk("wdt flags", {timeoutFlag, powerdownFlag}, pd ? 0 : 1);
            tick(1);
            chk("wdt end", coreReset, 0);
        end
        drive_pin(1, 8);
        chk("ext reset", coreReset, 1);
        chk("ext flags", {timeoutFlag, powerdownFlag}, 2);
        drive_pin(0, 12);
        chk("ext end", coreReset, 0);
        @(posedge clk);
        powerDownMode <= 1'b0;
        bus(1, pors_pkg::ADDR_STATUS, 32'h6);
        drive_pin(1, 8);
        chk("ext active", {timeoutFlag, powerdownFlag}, 3);
        drive_pin(0, 12);
    endtask

    task automatic t_brownout();
        @(posedge clk);
        sag <= 1'b1;
        tick(6);
        chk("bor reset", coreReset, 1);
        bus(0, pors_pkg::ADDR_STATUS, 0);
        chk("bor status", q[3], 1);
        tick(20);
        chk("bor held", coreReset, 1);
        @(posedge clk);
        sag <= 1'b0;
        tick(6);
        chk("bor end", coreReset, 0);
        bus(1, pors_pkg::ADDR_CONFIG, 3);
        bus(0, pors_pkg::ADDR_CONFIG, 0);
        chk("config", q, 3);
        sag <= 1'b1;
        tick(8);
        chk("bor off", coreReset, 0);
        bus(0, pors_pkg::ADDR_STATUS, 0);
        chk("bor off status", q[3], 0);
        @(posedge clk);
        sag <= 1'b0;
        hsize <= 3'h0;
        // byte-sized write must be ignored
        bus(1, pors_pkg::ADDR_CONFIG, 0);
        hsize <= 3'h2;
        // unmapped write must not alias onto config
        bus(1, 32'h100, 0);
        bus(0, 32'h100, 0);
        chk("unmapped", q, 0);
        bus(0, pors_pkg::ADDR_CONFIG, 0);
        chk("config kept", q, 3);
        chk("resp", hresp, 0);
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        t_power_on();
        t_watchdog();
        t_brownout();
        report_and_stop();
    end
endmodule // test_power_on_reset_sequencer

`default_nettype wire
